// *** verilog/cte_exec.sv ***
// Purpose: Execution datapath for 8/16-bit transfer, exchange and 8-bit ALU ops.
// Assumes: Memory operand byte is presented with the instruction.
// Notes: Counts one busy cycle per CPU clock; fetch assumed internal ROM.
`timescale 1ns/1ps

// Behaviour
// - One timing clock is one CPU clock
// - Fast column for high-speed RAM or none
// - Other areas and SFRs use slow column
// - Add read waits for external reads
// - Add write waits for external writes
// - Counts valid only for internal ROM fetch
// - Word pair moves use pairs 1..3, 4 clocks
// - Add immediate to saddr writes back, sets carry
// - Add-with-carry adds byte plus old carry
// - Pointer-displacement subtract keeps difference, borrow
// - Subtract-with-borrow immediate stores back result
module cte_exec (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic start,
   input cte_pkg::cte_instr_type instr,
   input wire logic [7:0] memData,
   input wire logic [7:0] regData,
   input wire logic [15:0] pairData,
   input wire logic [15:0] pointerPair,
   input wire logic [7:0] idxData,
   input wire logic [cte_pkg::WAIT_W-1:0] readWaits,
   input wire logic [cte_pkg::WAIT_W-1:0] writeWaits,
   input wire logic internalRomFetch,
   output logic busy,
   output logic done,
   output logic badOperand,
   output logic [15:0] effAddr,
   output logic [7:0] acc,
   output logic [7:0] xReg,
   output logic [15:0] wordOut,
   output logic wordWrite,
   output logic [7:0] resultOut,
   output logic regWrite,
   output logic memWrite,
   output cte_pkg::cte_flags_type flags,
   output logic [5:0] cycleCount,
   output logic [1:0] instrLength,
   output logic timingExact
);

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} cte_state_type;

   cte_state_type state_r;
   cte_pkg::cte_instr_type instr_r;
   logic [5:0] remain_r;
   logic [5:0] cycles;
   logic [1:0] length;
   logic [7:0] opnd;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] lhs;
   logic isSub;
   logic useCarry;
   logic [7:0] result;
   cte_pkg::cte_flags_type flagsNxt;
   logic inFastRam;
   logic inExt;
   logic illegalPair;
   logic [7:0] acc_r;
   logic [7:0] x_r;

   // ----------------------------------------
   // Operand fetch and address areas
   // ----------------------------------------
   always_comb begin
      case (instr.src)
         cte_pkg::SRC_PTR: effAddr = pointerPair;
         cte_pkg::SRC_PTR_DISP: effAddr = pointerPair + {8'h00, instr.imm};
         cte_pkg::SRC_PTR_IDX: effAddr = pointerPair + {8'h00, idxData};
         default: effAddr = instr.addr;
      endcase
   end

   assign inFastRam = instr.src != cte_pkg::SRC_SFR && effAddr >= cte_pkg::HSRAM_LO && effAddr <= cte_pkg::SADDR_HI
      && !(effAddr >= cte_pkg::SFR_LO);
   assign inExt = effAddr >= cte_pkg::EXT_LO && effAddr <= cte_pkg::EXT_HI;
   assign illegalPair = instr.op inside {cte_pkg::OP_WORD_MOVE_OP_TO_AX, cte_pkg::OP_WORD_MOVE_OP_FROM_AX, cte_pkg::OP_WORD_EXCHANGE_OP}
      && instr.pairSel == cte_pkg::PAIR_ACC;

   cte_timing u_timing (
      .instr(instr),
      .inFastRam(inFastRam),
      .inExt(inExt),
      .readWaits(readWaits),
      .writeWaits(writeWaits),
      .cycles(cycles),
      .length(length)
   );

   // ----------------------------------------
   // Arithmetic and logic
   // ----------------------------------------
   always_comb begin
      case (instr.src)
         cte_pkg::SRC_IMM: opnd = instr.imm;
         cte_pkg::SRC_REG: opnd = (instr.dst == cte_pkg::DST_REG) ? acc_r : regData;
         default: opnd = memData;
      endcase
      // Immediate-to-memory forms operate on the memory byte
      if (instr.src == cte_pkg::SRC_IMM && instr.dst == cte_pkg::DST_MEM) begin
         lhs = memData;
      end else if (instr.dst == cte_pkg::DST_REG) begin
         lhs = regData;
      end else begin
         lhs = acc_r;
      end
      isSub = instr.op inside {cte_pkg::OP_SUB, cte_pkg::OP_SUBTRACT_WITH_BORROW_OP, cte_pkg::OP_CMP};
      useCarry = (instr.op == cte_pkg::OP_ADD_WITH_CARRY_OP || instr.op == cte_pkg::OP_SUBTRACT_WITH_BORROW_OP) && flags.carry;
      if (isSub) begin
         sum = {1'b0, lhs} - {1'b0, opnd} - {8'h00, useCarry};
         nib = {1'b0, lhs[3:0]} - {1'b0, opnd[3:0]} - {4'h0, useCarry};
      end else begin
         sum = {1'b0, lhs} + {1'b0, opnd} + {8'h00, useCarry};
         nib = {1'b0, lhs[3:0]} + {1'b0, opnd[3:0]} + {4'h0, useCarry};
      end
      flagsNxt = flags;
      result = sum[7:0];
      case (instr.op)
         cte_pkg::OP_AND, cte_pkg::OP_OR, cte_pkg::OP_XOR: begin
            result = (instr.op == cte_pkg::OP_AND) ? (lhs & opnd)
               : (instr.op == cte_pkg::OP_OR) ? (lhs | opnd) : (lhs ^ opnd);
            flagsNxt.zero = (result == 8'h00);
         end
         cte_pkg::OP_ADD, cte_pkg::OP_ADD_WITH_CARRY_OP, cte_pkg::OP_SUB, cte_pkg::OP_SUBTRACT_WITH_BORROW_OP, cte_pkg::OP_CMP: begin
            flagsNxt.zero = (sum[7:0] == 8'h00);
            flagsNxt.auxCarry = nib[4];
            flagsNxt.carry = sum[8];
         end
         // A non-immediate store to memory carries the accumulator, not the old memory byte
         cte_pkg::OP_MOV: begin
            result = (instr.dst == cte_pkg::DST_MEM && instr.src != cte_pkg::SRC_IMM) ? acc_r : opnd;
         end
         cte_pkg::OP_XCH: result = opnd;
         default: result = opnd;
      endcase
   end

   // ----------------------------------------
   // Sequencer: one count per CPU clock
   // ----------------------------------------
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= ST_IDLE;
         remain_r <= 6'h00;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start && !illegalPair) begin
                  state_r <= (cycles > 6'h01) ? ST_RUN : ST_DONE;
                  remain_r <= cycles - 6'h01;
               end
            end
            ST_RUN: begin
               remain_r <= remain_r - 6'h01;
               if (remain_r == 6'h01) begin
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Latch instruction info and results at issue
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         instr_r <= '0;
         acc_r <= 8'h00;
         x_r <= 8'h00;
         flags <= '0;
         resultOut <= 8'h00;
         wordOut <= 16'h0000;
         regWrite <= 1'b0;
         memWrite <= 1'b0;
         wordWrite <= 1'b0;
         cycleCount <= 6'h00;
         instrLength <= 2'h0;
         timingExact <= 1'b0;
         badOperand <= 1'b0;
      end else begin
         regWrite <= 1'b0;
         memWrite <= 1'b0;
         wordWrite <= 1'b0;
         badOperand <= 1'b0;
         if (state_r == ST_IDLE && start) begin
            badOperand <= illegalPair;
            if (!illegalPair) begin
               instr_r <= instr;
               flags <= flagsNxt;
               cycleCount <= cycles;
               instrLength <= length;
               timingExact <= internalRomFetch;
               resultOut <= result;
               case (instr.op)
                  cte_pkg::OP_WORD_MOVE_OP_TO_AX: begin
                     {x_r, acc_r} <= {pairData[7:0], pairData[15:8]};
                  end
                  cte_pkg::OP_WORD_MOVE_OP_FROM_AX: begin
                     wordOut <= {acc_r, x_r};
                     wordWrite <= 1'b1;
                  end
                  cte_pkg::OP_WORD_EXCHANGE_OP: begin
                     {x_r, acc_r} <= {pairData[7:0], pairData[15:8]};
                     wordOut <= {acc_r, x_r};
                     wordWrite <= 1'b1;
                  end
                  cte_pkg::OP_CMP: begin
                  end
                  cte_pkg::OP_XCH: begin
                     acc_r <= opnd;
                     resultOut <= acc_r;
                     regWrite <= instr.src == cte_pkg::SRC_REG;
                     memWrite <= instr.src != cte_pkg::SRC_REG;
                  end
                  default: begin
                     if (instr.dst == cte_pkg::DST_ACC) begin
                        acc_r <= result;
                     end
                     regWrite <= instr.dst == cte_pkg::DST_REG;
                     memWrite <= instr.dst == cte_pkg::DST_MEM;
                  end
               endcase
            end
         end
      end
   end

   assign busy = state_r != ST_IDLE;
   assign done = state_r == ST_DONE;
   assign acc = acc_r;
   assign xReg = x_r;

endmodule

// *** verilog/cte_pkg.sv ***
// Purpose: Shared types and constants for the transfer/arithmetic execution datapath.
// Assumes: One instruction clock equals one CPU clock cycle.
// Notes: Cycle figures are the base values before memory wait states.
package cte_pkg;

   // ----------------------------------------
   // Operation and operand classes
   // ----------------------------------------
   typedef enum logic [3:0] {
      OP_MOV, OP_XCH, OP_ADD, OP_ADD_WITH_CARRY_OP, OP_SUB, OP_SUBTRACT_WITH_BORROW_OP,
      OP_AND, OP_OR, OP_XOR, OP_CMP, OP_WORD_MOVE_OP_TO_AX, OP_WORD_MOVE_OP_FROM_AX, OP_WORD_EXCHANGE_OP
   } cte_op_type;

   // Where the second operand lives
   typedef enum logic [2:0] {
      SRC_IMM, SRC_REG, SRC_SADDR, SRC_SFR, SRC_ABS, SRC_PTR, SRC_PTR_DISP, SRC_PTR_IDX
   } cte_src_type;

   // Where the result goes
   typedef enum logic [1:0] {
      DST_ACC, DST_REG, DST_MEM
   } cte_dst_type;

   typedef struct packed {
      cte_op_type op;
      cte_src_type src;
      cte_dst_type dst;
      logic [2:0] regSel;
      logic [1:0] pairSel;
      logic [7:0] imm;
      logic [15:0] addr;
   } cte_instr_type;

   typedef struct packed {
      logic zero;
      logic auxCarry;
      logic carry;
   } cte_flags_type;

   // ----------------------------------------
   // Address areas
   // ----------------------------------------
   localparam logic [15:0] HSRAM_LO = 16'hfb00;
   localparam logic [15:0] HSRAM_HI = 16'hfeff;
   localparam logic [15:0] SADDR_HI = 16'hff1f;
   localparam logic [15:0] SFR_LO = 16'hff00;
   localparam logic [15:0] EXT_LO = 16'h8000;
   localparam logic [15:0] EXT_HI = 16'hf7ff;

   // ----------------------------------------
   // Base cycle counts and lengths
   // ----------------------------------------
   localparam logic [4:0] CYC_IMM_SFR = 5'h07;
   localparam logic [4:0] CYC_ABS_LONG = 5'h09;
   localparam logic [4:0] CYC_WORD_PAIR = 5'h04;
   localparam logic [4:0] CYC_SADDR_ALU_FAST = 5'h06;
   localparam logic [4:0] CYC_SADDR_ALU_SLOW = 5'h08;
   localparam logic [4:0] CYC_ABS_ALU_FAST = 5'h08;
   localparam logic [4:0] CYC_ALU_FAST = 5'h04;
   localparam logic [4:0] CYC_ALU_SLOW = 5'h05;
   localparam logic [4:0] CYC_ONE = 5'h01;
   localparam logic [4:0] CYC_REG_MOVE = 5'h02;
   localparam logic [4:0] CYC_XCH_SLOW = 5'h06;
   localparam logic [1:0] LEN_ONE = 2'h1;
   localparam logic [1:0] LEN_TWO = 2'h2;
   localparam logic [1:0] LEN_THREE = 2'h3;
   localparam logic [1:0] PAIR_ACC = 2'h0;
   localparam logic [2:0] REG_ACC = 3'h1;
   localparam int WAIT_W = 4;

endpackage

// *** verilog/cte_timing.sv ***
// Purpose: Cycle count and length lookup for one instruction.
// Assumes: Program fetched from internal ROM.
// Notes: Wait states for the external area are added on top.
`timescale 1ns/1ps
module cte_timing (
   input cte_pkg::cte_instr_type instr,
   input wire logic inFastRam,
   input wire logic inExt,
   input wire logic [cte_pkg::WAIT_W-1:0] readWaits,
   input wire logic [cte_pkg::WAIT_W-1:0] writeWaits,
   output logic [5:0] cycles,
   output logic [1:0] length
);

   logic [4:0] base;
   logic [4:0] slow;
   logic [4:0] fast;
   logic memSrc;
   logic isRd;
   logic isWr;

   // Fast and slow base columns per operand class
   always_comb begin
      fast = cte_pkg::CYC_ALU_FAST;
      slow = cte_pkg::CYC_ALU_SLOW;
      length = cte_pkg::LEN_TWO;
      memSrc = 1'b0;
      case (instr.src)
         cte_pkg::SRC_IMM: begin
            if (instr.dst == cte_pkg::DST_MEM) begin
               fast = cte_pkg::CYC_SADDR_ALU_FAST;
               slow = (instr.op == cte_pkg::OP_MOV) ? cte_pkg::CYC_IMM_SFR : cte_pkg::CYC_SADDR_ALU_SLOW;
               length = cte_pkg::LEN_THREE;
               memSrc = 1'b1;
            end
         end
         cte_pkg::SRC_REG: begin
            if (instr.op inside {cte_pkg::OP_WORD_MOVE_OP_TO_AX, cte_pkg::OP_WORD_MOVE_OP_FROM_AX, cte_pkg::OP_WORD_EXCHANGE_OP}) begin
               fast = cte_pkg::CYC_WORD_PAIR;
               length = cte_pkg::LEN_ONE;
            end else if (instr.op inside {cte_pkg::OP_MOV, cte_pkg::OP_XCH}) begin
               fast = cte_pkg::CYC_REG_MOVE;
               length = cte_pkg::LEN_ONE;
            end
         end
         cte_pkg::SRC_SADDR, cte_pkg::SRC_SFR: begin
            memSrc = 1'b1;
            slow = (instr.op == cte_pkg::OP_XCH) ? cte_pkg::CYC_XCH_SLOW : cte_pkg::CYC_ALU_SLOW;
         end
         cte_pkg::SRC_ABS: begin
            fast = cte_pkg::CYC_ABS_ALU_FAST;
            slow = cte_pkg::CYC_ABS_LONG;
            length = cte_pkg::LEN_THREE;
            memSrc = 1'b1;
         end
         cte_pkg::SRC_PTR: begin
            slow = cte_pkg::CYC_ALU_SLOW;
            length = cte_pkg::LEN_ONE;
            memSrc = 1'b1;
         end
         cte_pkg::SRC_PTR_DISP: begin
            fast = cte_pkg::CYC_ABS_ALU_FAST;
            slow = cte_pkg::CYC_ABS_LONG;
            memSrc = 1'b1;
         end
         default: begin
            fast = cte_pkg::CYC_ABS_ALU_FAST;
            slow = cte_pkg::CYC_ABS_LONG;
            memSrc = 1'b1;
         end
      endcase
   end

   // Column choice: fast only for internal high-speed RAM or no data access
   assign base = (memSrc && !inFastRam) ? slow : fast;
   assign isWr = memSrc && instr.dst == cte_pkg::DST_MEM;
   assign isRd = memSrc && !(instr.op == cte_pkg::OP_MOV && instr.dst == cte_pkg::DST_MEM);
   assign cycles = {1'b0, base}
      + ((inExt && isRd) ? {2'b00, readWaits} : 6'h00)
      + ((inExt && isWr) ? {2'b00, writeWaits} : 6'h00);

endmodule

// *** testbench/cte_exec_monitor.sv ***
// Purpose: Port-level timing and flag checks for the execution datapath.
// Assumes: One busy cycle per CPU clock, fetch from internal ROM.
// Notes: Bound to cte_exec from the bench top file.
`timescale 1ns/1ps
module cte_exec_monitor (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic start,
   input cte_pkg::cte_instr_type instr,
   input wire logic [7:0] memData,
   input wire logic [cte_pkg::WAIT_W-1:0] readWaits,
   input wire logic [cte_pkg::WAIT_W-1:0] writeWaits,
   input wire logic internalRomFetch,
   input wire logic busy,
   input wire logic done,
   input wire logic badOperand,
   input wire logic [7:0] acc,
   input wire logic wordWrite,
   input wire logic [7:0] resultOut,
   input wire logic regWrite,
   input wire logic memWrite,
   input cte_pkg::cte_flags_type flags,
   input wire logic [5:0] cycleCount,
   input wire logic [1:0] instrLength,
   input wire logic timingExact
);
   // -----------------------------
   // Helper logic
   // -----------------------------
   logic [5:0] cnt_r;
   wire logic take = start && !busy;
   wire logic wordBad = instr.pairSel == 2'h0
      && instr.op inside {cte_pkg::OP_WORD_MOVE_OP_TO_AX, cte_pkg::OP_WORD_MOVE_OP_FROM_AX, cte_pkg::OP_WORD_EXCHANGE_OP};
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);

   // Edges since the last accepted instruction
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r <= 6'h00;
      end else if (take) begin
         cnt_r <= 6'h01;
      end else begin
         cnt_r <= cnt_r + 6'h01;
      end
   end

   // -----------------------------
   // Assertions
   // -----------------------------
   sequence s_take;
      take;
   endsequence
   sequence s_imm_mem(cte_pkg::cte_op_type o);
      s_take ##0 (instr.op == o && instr.src == cte_pkg::SRC_IMM && instr.dst == cte_pkg::DST_MEM);
   endsequence
   sequence s_ext(cte_pkg::cte_dst_type d);
      s_take ##0 (instr.op == cte_pkg::OP_MOV && instr.src == cte_pkg::SRC_ABS && instr.dst == d
         && instr.addr inside {[cte_pkg::EXT_LO:cte_pkg::EXT_HI]});
   endsequence

   a_done_on_count: assert property (done |-> cnt_r == cycleCount)
      else $error("done not at the counted clock");
   a_fast_add_back: assert property (s_imm_mem(cte_pkg::OP_ADD) ##0 (instr.addr >= cte_pkg::HSRAM_LO
      && instr.addr < cte_pkg::SFR_LO) |=>
      cycleCount == 6'h06 && instrLength == 2'h3 && memWrite && resultOut == 8'($past(instr.imm) + $past(memData)))
      else $error("fast add to memory wrong");
   a_sfr_slow: assert property (s_imm_mem(cte_pkg::OP_MOV) ##0 instr.addr >= cte_pkg::SFR_LO |=>
      cycleCount == 6'h07) else $error("immediate to sfr not 7 clocks");
   a_ext_read_wait: assert property (s_ext(cte_pkg::DST_ACC) |=>
      cycleCount == 6'h09 + 6'($past(readWaits))) else $error("external read waits wrong");
   a_ext_write_wait: assert property (s_ext(cte_pkg::DST_MEM) |=>
      cycleCount == 6'h09 + 6'($past(writeWaits))) else $error("external write waits wrong");
   a_rom_timing: assert property (s_take ##0 !wordBad |=> timingExact == $past(internalRomFetch))
      else $error("timing exact flag wrong");
   a_word_refused: assert property (s_take ##0 (instr.pairSel == 2'h0 && instr.op inside
      {cte_pkg::OP_WORD_MOVE_OP_TO_AX, cte_pkg::OP_WORD_MOVE_OP_FROM_AX, cte_pkg::OP_WORD_EXCHANGE_OP}) |=>
      badOperand && !wordWrite && acc == $past(acc)) else $error("word op on first pair not refused");
   a_logic_flags: assert property (s_take ##0 instr.op inside {cte_pkg::OP_AND, cte_pkg::OP_OR, cte_pkg::OP_XOR} |=>
      flags.carry == $past(flags.carry) && flags.auxCarry == $past(flags.auxCarry)) else $error("logic op changed carry");
   a_cmp_no_write: assert property (s_take ##0 instr.op == cte_pkg::OP_CMP |=>
      !memWrite && !regWrite && acc == $past(acc)) else $error("compare wrote a result");
endmodule

// *** testbench/cte_mem_model.sv ***
// Purpose: Byte memory standing behind the datapath's operand port.
// Assumes: Reads are combinational on the effective address.
// Notes: A few bytes are preloaded for the bench.
`timescale 1ns/1ps
module cte_mem_model (
   input wire logic clock,
   input wire logic [15:0] effAddr,
   input wire logic memWrite,
   input wire logic [7:0] resultOut,
   output logic [7:0] memData
);
   logic [7:0] mem [0:65535];
   // Clear, then place the operands read by the bench
   initial begin
      for (int k = 0; k < 65536; k++) begin
         mem[k] = 8'h00;
      end
      mem[16'h8100] = 8'h41;
      mem[16'hfe80] = 8'h0f;
      mem[16'hfe10] = 8'h60;
   end
   // Store bytes written back by the core
   always @(posedge clock) begin
      if (memWrite === 1'b1) begin
         mem[effAddr] <= resultOut;
      end
   end
   assign memData = mem[effAddr];
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the execution datapath.
// Assumes: Instruction held until done; memory through the model.
// Notes: Rows hold ordinary cases; hazards follow by hand.
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      cte_pkg::cte_instr_type i;
      logic [3:0] w;
      logic [5:0] cyc;
      logic [1:0] len;
      logic [7:0] a;
      logic [2:0] f;
      logic [7:0] res;
   } cte_row_type;
   logic clock, sys_rst, start, internalRomFetch, busy, done, badOperand, wordWrite, regWrite, memWrite, timingExact;
   cte_pkg::cte_instr_type instr;
   cte_pkg::cte_flags_type flags;
   logic [7:0] memData, acc, xReg, resultOut;
   logic [15:0] pairData, effAddr, wordOut;
   logic [3:0] readWaits, writeWaits;
   logic [5:0] cycleCount;
   logic [1:0] instrLength;
   int mismatches, comparisons;
   cte_row_type rows[$];

   cte_exec dut (.clock(clock), .sys_rst(sys_rst), .start(start), .instr(instr), .memData(memData),
      .regData(8'h00), .pairData(pairData), .pointerPair(16'hfe00), .idxData(8'h00), .readWaits(readWaits),
      .writeWaits(writeWaits), .internalRomFetch(internalRomFetch), .busy(busy), .done(done),
      .badOperand(badOperand), .effAddr(effAddr), .acc(acc), .xReg(xReg), .wordOut(wordOut),
      .wordWrite(wordWrite), .resultOut(resultOut), .regWrite(regWrite), .memWrite(memWrite), .flags(flags),
      .cycleCount(cycleCount), .instrLength(instrLength), .timingExact(timingExact));
   cte_mem_model mem (.clock(clock), .effAddr(effAddr), .memWrite(memWrite), .resultOut(resultOut),
      .memData(memData));

   // -----------------------------
   // Helpers
   // -----------------------------
   function automatic cte_row_type r(cte_pkg::cte_op_type o, cte_pkg::cte_src_type s, logic m, logic [7:0] im,
      logic [15:0] ad, logic [3:0] w, logic [5:0] c, logic [1:0] l, logic [7:0] a, logic [2:0] f, logic [7:0] rs);
      r = '{'{o, s, m ? cte_pkg::DST_MEM : cte_pkg::DST_ACC, 3'h0, ad[1:0], im, ad}, w, c, l, a, f, rs};
   endfunction
   task automatic check(string n, logic [31:0] e, logic [31:0] s);
      comparisons++;
      if (e !== s) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic issue(cte_pkg::cte_instr_type i, logic [3:0] w);
      @(posedge clock);
      start <= 1'b1;
      instr <= i;
      pairData <= i.addr;
      readWaits <= w;
      writeWaits <= w;
      @(posedge clock);
      start <= 1'b0;
   endtask
   task automatic wait_done();
      for (int k = 0; k < 40; k++) begin
         @(negedge clock);
         if (done === 1'b1) return;
      end
      // A missing end of instruction counts against the run
      mismatches++;
      $display("BAD done expected 1 seen %b", done);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Clock source
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Watchdog
   initial begin
      #20000;
      mismatches++;
      finish_test();
   end

   // -----------------------------
   // Main sequence
   // -----------------------------
   initial begin
      sys_rst = 1'b1;
      start = 1'b0;
      instr = '0;
      pairData = 16'h0000;
      readWaits = 4'h0;
      writeWaits = 4'h0;
      internalRomFetch = 1'b1;
      rows.push_back(r(cte_pkg::OP_MOV, cte_pkg::SRC_IMM, 1, 8'h33, 16'hfe20, 0, 6, 3, 8'h00, 0, 8'h33));
      rows.push_back(r(cte_pkg::OP_MOV, cte_pkg::SRC_IMM, 1, 8'h44, 16'hff10, 0, 7, 3, 8'h00, 0, 8'h44));
      rows.push_back(r(cte_pkg::OP_MOV, cte_pkg::SRC_ABS, 0, 8'h00, 16'h8100, 3, 12, 3, 8'h41, 0, 0));
      rows.push_back(r(cte_pkg::OP_MOV, cte_pkg::SRC_ABS, 1, 8'h00, 16'h8200, 2, 11, 3, 8'h41, 0, 8'h41));
      rows.push_back(r(cte_pkg::OP_ADD, cte_pkg::SRC_IMM, 1, 8'he0, 16'hfe20, 0, 6, 3, 8'h41, 1, 8'h13));
      rows.push_back(r(cte_pkg::OP_ADD_WITH_CARRY_OP, cte_pkg::SRC_ABS, 0, 8'h00, 16'hfe80, 0, 8, 3, 8'h51, 2, 0));
      rows.push_back(r(cte_pkg::OP_SUB, cte_pkg::SRC_PTR_DISP, 0, 8'h10, 0, 0, 8, 2, 8'hf1, 1, 0));
      rows.push_back(r(cte_pkg::OP_AND, cte_pkg::SRC_IMM, 0, 8'h0e, 0, 0, 4, 2, 8'h00, 5, 0));
      rows.push_back(r(cte_pkg::OP_SUBTRACT_WITH_BORROW_OP, cte_pkg::SRC_IMM, 1, 8'h05, 16'hfe20, 0, 6, 3, 8'h00, 2, 8'h0d));
      rows.push_back(r(cte_pkg::OP_CMP, cte_pkg::SRC_IMM, 0, 8'h01, 0, 0, 4, 2, 8'h00, 3, 0));
      rows.push_back(r(cte_pkg::OP_OR, cte_pkg::SRC_IMM, 0, 8'h00, 0, 0, 4, 2, 8'h00, 7, 0));
      rows.push_back(r(cte_pkg::OP_XOR, cte_pkg::SRC_IMM, 0, 8'h5a, 0, 0, 4, 2, 8'h5a, 3, 0));
      rows.push_back(r(cte_pkg::OP_WORD_MOVE_OP_TO_AX, cte_pkg::SRC_REG, 0, 0, 16'h1231, 0, 4, 1, 8'h12, 3, 0));
      rows.push_back(r(cte_pkg::OP_WORD_EXCHANGE_OP, cte_pkg::SRC_REG, 0, 0, 16'habce, 0, 4, 1, 8'hab, 3, 0));
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      check("reset", 0, {busy, done, acc, flags, cycleCount});
      $display("test reset ended");
      // Ordinary cases
      foreach (rows[k]) begin
         issue(rows[k].i, rows[k].w);
         wait_done();
         check("cycles", rows[k].cyc, cycleCount);
         check("length", rows[k].len, instrLength);
         check("acc", rows[k].a, acc);
         check("flags", rows[k].f, flags);
         check("exact", 1, timingExact);
         if (rows[k].i.dst == cte_pkg::DST_MEM) check("result", rows[k].res, resultOut);
         $display("test row %0d ended", k);
      end
      check("word", {16'h1231, 8'hce}, {wordOut, xReg});
      check("stored", {8'h41, 8'h0d}, {mem.mem[16'h8200], mem.mem[16'hfe20]});
      // Start held high through a busy instruction is ignored
      @(posedge clock);
      start <= 1'b1;
      instr <= rows[1].i;
      @(posedge clock);
      @(posedge clock);
      instr <= rows[9].i;
      wait_done();
      @(posedge clock);
      start <= 1'b0;
      @(negedge clock);
      check("held start", {6'h07, 3'h3}, {cycleCount, flags});
      $display("test busy ended");
      // Word move on the first pair is refused
      issue(r(cte_pkg::OP_WORD_MOVE_OP_TO_AX, cte_pkg::SRC_REG, 0, 0, 16'h5550, 0, 0, 0, 0, 0, 0).i, 4'h0);
      @(negedge clock);
      check("refused", {1'b1, 8'hab}, {badOperand, acc});
      $display("test refused ended");
      // Fetch outside internal ROM
      internalRomFetch <= 1'b0;
      issue(rows[7].i, 4'h0);
      wait_done();
      check("exact", 0, timingExact);
      $display("test fetch ended");
      finish_test();
   end
endmodule

bind cte_exec cte_exec_monitor u_mon (.clock(clock), .sys_rst(sys_rst), .start(start), .instr(instr),
   .memData(memData), .readWaits(readWaits), .writeWaits(writeWaits), .internalRomFetch(internalRomFetch),
   .busy(busy), .done(done), .badOperand(badOperand), .acc(acc), .wordWrite(wordWrite), .resultOut(resultOut),
   .regWrite(regWrite), .memWrite(memWrite), .flags(flags), .cycleCount(cycleCount), .instrLength(instrLength),
   .timingExact(timingExact));
